// file: core/clock_gen.sv
// Purpose: clock generator with pll dividers, detectors and base clock selector
// Assumes: oscillator and vco clocks arrive as pins far slower than CLK
// Notes: analog vco and loop filter are outside; this drives their controls
//
// The address map and the plain strobed port were left to the implementer.
module clock_gen
    import clock_gen_pkg::*;
#(
    parameter int TRACK_N = TRACK_PERIODS,
    parameter int LOCK_N = LOCK_PERIODS
) (
    // clock, reset, enable
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CE,
    // register port
    input wire logic [2:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    // clock pins
    input wire logic OSC_CLK,
    input wire logic VCO_CLK,
    // generated clocks
    output logic BASE_CLOCK_OUT,
    output logic BUS_CLOCK,
    output logic DIVIDED_REFERENCE,
    output logic FEEDBACK_CLOCK,
    // loop controls
    output logic PUMP_UP,
    output logic PUMP_DN,
    output logic FILTER_TRACK,
    output logic VCO_ENABLE,
    output logic [7:0] VCO_RANGE,
    output logic [1:0] VCO_EXP,
    output logic [31:0] VCO_CENTER_HZ,
    // interrupt
    output logic CLOCK_IRQ
);

    localparam logic [CNT_W-1:0] TRACK_C = CNT_W'(TRACK_N);
    localparam logic [CNT_W-1:0] LOCK_C = CNT_W'(LOCK_N);

    state_type s_r;
    state_type s_nxt;

    // prescaled vco level for the current power-of-two setting
    function automatic logic pclk_lvl(input logic [1:0] p, input logic v, input logic [2:0] c);
        logic r;
        r = v;
        if (p != 2'h0) begin
            r = c[p-2'h1];
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    logic osc_rise;
    logic vco_rise;
    logic pclk_rise;
    logic ref_now;
    logic fb_now;
    logic hw_track;
    logic range_zero;
    logic lock_new;
    logic flag_set;
    logic osc_fall;
    logic pclk_fall;
    logic safe_edge;
    src_type want;

    always_comb begin
        s_nxt = s_r;
        osc_rise = 1'b0;
        vco_rise = 1'b0;
        pclk_rise = 1'b0;
        ref_now = 1'b0;
        fb_now = 1'b0;
        lock_new = s_r.lock;
        flag_set = 1'b0;
        want = SRC_OSC;
        range_zero = (s_r.range == 8'h00);

        // pin inputs: three stages, level accepted when last two agree
        s_nxt.osc_s = {s_r.osc_s[1:0], OSC_CLK};
        s_nxt.vco_s = {s_r.vco_s[1:0], VCO_CLK};
        if (s_r.osc_s[1] == s_r.osc_s[2]) begin
            s_nxt.osc_st = s_r.osc_s[2];
        end
        if (s_r.vco_s[1] == s_r.vco_s[2]) begin
            s_nxt.vco_st = s_r.vco_s[2];
        end
        osc_rise = s_nxt.osc_st & ~s_r.osc_st;
        vco_rise = s_nxt.vco_st & ~s_r.vco_st;

        // reference divider
        if (osc_rise) begin
            if (s_r.ref_cnt + RDIV_W'(1) >= s_r.rdiv) begin
                s_nxt.ref_cnt = '0;
                ref_now = s_r.pwr;
            end else begin
                s_nxt.ref_cnt = s_r.ref_cnt + RDIV_W'(1);
            end
        end
        s_nxt.ref_pulse = ref_now;

        // prescaler and modulo feedback divider
        if (vco_rise && s_r.pwr) begin
            s_nxt.pre_cnt = s_r.pre_cnt + 3'h1;
        end
        pclk_rise = s_r.pwr &&
            pclk_lvl(s_r.p_exp, s_nxt.vco_st, s_nxt.pre_cnt) &&
            !pclk_lvl(s_r.p_exp, s_r.vco_st, s_r.pre_cnt);
        if (pclk_rise) begin
            if (s_r.fb_cnt + MULT_W'(1) >= s_r.mult) begin
                s_nxt.fb_cnt = '0;
                fb_now = 1'b1;
            end else begin
                s_nxt.fb_cnt = s_r.fb_cnt + MULT_W'(1);
            end
        end
        s_nxt.fb_pulse = fb_now;

        // phase-frequency detector, both pumps cancel once both are set
        s_nxt.pd_up = s_r.pd_up | ref_now;
        s_nxt.pd_dn = s_r.pd_dn | fb_now;
        if ((s_nxt.pd_up && s_nxt.pd_dn) || !s_r.pwr) begin
            s_nxt.pd_up = 1'b0;
            s_nxt.pd_dn = 1'b0;
        end

        // lock detector: exactly one feedback edge per reference period
        if (fb_now && s_r.fb_seen != 2'h3) begin
            s_nxt.fb_seen = s_r.fb_seen + 2'h1;
        end
        if (ref_now) begin
            s_nxt.fb_seen = {1'b0, fb_now};
            if (s_r.fb_seen == 2'h1) begin
                if (s_r.good_cnt != LOCK_C) begin
                    s_nxt.good_cnt = s_r.good_cnt + CNT_W'(1);
                end
            end else begin
                s_nxt.good_cnt = '0;
            end
        end
        if (!s_r.pwr) begin
            s_nxt.good_cnt = '0;
            s_nxt.fb_seen = 2'h0;
            s_nxt.pre_cnt = 3'h0;
            s_nxt.fb_cnt = '0;
        end
        hw_track = (s_nxt.good_cnt >= TRACK_C);
        lock_new = (s_nxt.good_cnt >= LOCK_C);
        s_nxt.lock = lock_new;
        flag_set = s_r.auto_bw && s_r.irq_en && (lock_new != s_r.lock);

        // register writes
        if (REG_WR) begin
            unique case (REG_ADDR)
                OFS_CTRL: begin
                    s_nxt.irq_en = REG_WDATA[CTRL_IRQ_EN] & s_r.auto_bw;
                    s_nxt.pwr = REG_WDATA[CTRL_PWR] | s_r.bsel;
                    s_nxt.bsel = REG_WDATA[CTRL_BSEL] & s_nxt.pwr & ~range_zero;
                    s_nxt.e_exp = REG_WDATA[CTRL_E_LSB+:2];
                    s_nxt.p_exp = REG_WDATA[CTRL_P_LSB+:2];
                end
                OFS_BW: begin
                    s_nxt.auto_bw = REG_WDATA[BW_AUTO];
                    s_nxt.halve = REG_WDATA[BW_HALVE];
                    if (!s_r.auto_bw) begin
                        s_nxt.mode_sw = REG_WDATA[BW_MODE];
                    end
                end
                OFS_MULT_HI: begin
                    if (!s_r.pwr) begin
                        s_nxt.mult[MULT_W-1:8] = REG_WDATA[MULT_W-9:0];
                    end
                end
                OFS_MULT_LO: begin
                    if (!s_r.pwr) begin
                        s_nxt.mult[7:0] = REG_WDATA;
                    end
                end
                OFS_RANGE: begin
                    if (!s_r.pwr) begin
                        s_nxt.range = REG_WDATA;
                    end
                end
                OFS_REFDIV: begin
                    if (!s_r.pwr) begin
                        s_nxt.rdiv = REG_WDATA[RDIV_W-1:0];
                    end
                end
                default: begin
                end
            endcase
        end
        if (!s_nxt.auto_bw) begin
            s_nxt.irq_en = 1'b0;
        end
        if (s_nxt.bsel) begin
            s_nxt.pwr = 1'b1;
        end
        if (!s_nxt.pwr || s_nxt.range == 8'h00) begin
            s_nxt.bsel = 1'b0;
        end

        // flag clears on a control read; a new event in that cycle wins
        if (REG_RD && REG_ADDR == OFS_CTRL) begin
            s_nxt.flag = 1'b0;
        end
        if (flag_set) begin
            s_nxt.flag = 1'b1;
        end
        if (!s_nxt.auto_bw) begin
            s_nxt.flag = 1'b0;
        end

        // register reads, data in the following cycle
        s_nxt.rdata = 8'h00;
        if (REG_RD) begin
            unique case (REG_ADDR)
                OFS_CTRL: begin
                    s_nxt.rdata = {s_r.irq_en, s_r.flag & s_r.auto_bw, s_r.pwr,
                        s_r.bsel, s_r.e_exp, s_r.p_exp};
                end
                OFS_BW: begin
                    s_nxt.rdata[BW_AUTO] = s_r.auto_bw;
                    s_nxt.rdata[BW_LOCK] = s_r.lock & s_r.auto_bw;
                    s_nxt.rdata[BW_MODE] = s_r.auto_bw ? hw_track : s_r.mode_sw;
                    s_nxt.rdata[BW_HALVE] = s_r.halve;
                end
                OFS_MULT_HI: begin
                    s_nxt.rdata[MULT_W-9:0] = s_r.mult[MULT_W-1:8];
                end
                OFS_MULT_LO: begin
                    s_nxt.rdata = s_r.mult[7:0];
                end
                OFS_RANGE: begin
                    s_nxt.rdata = s_r.range;
                end
                OFS_REFDIV: begin
                    s_nxt.rdata[RDIV_W-1:0] = s_r.rdiv;
                end
                default: begin
                    s_nxt.rdata = 8'h00;
                end
            endcase
        end

        // switch on a falling edge of the new source, so it opens a whole low phase
        want = s_r.bsel ? SRC_PLL : (s_r.halve ? SRC_OSC_HALF : SRC_OSC);
        osc_fall = s_r.osc_st & ~s_nxt.osc_st;
        pclk_fall = s_r.pwr &&
            !pclk_lvl(s_r.p_exp, s_nxt.vco_st, s_nxt.pre_cnt) &&
            pclk_lvl(s_r.p_exp, s_r.vco_st, s_r.pre_cnt);
        safe_edge = (want == SRC_PLL) ? pclk_fall : osc_fall;
        if (osc_rise) begin
            s_nxt.half_t = ~s_r.half_t;
        end
        if (pclk_rise) begin
            s_nxt.pll_t = ~s_r.pll_t;
        end
        if (want != s_r.act_src && !s_r.base && safe_edge) begin
            s_nxt.act_src = want;
            s_nxt.half_t = 1'b0;
            s_nxt.pll_t = 1'b0;
        end
        unique case (s_nxt.act_src)
            SRC_OSC: s_nxt.base = s_nxt.osc_st;
            SRC_OSC_HALF: s_nxt.base = s_nxt.half_t;
            SRC_PLL: s_nxt.base = s_nxt.pll_t;
            default: s_nxt.base = 1'b0;
        endcase
        // bus clock toggles on every rising base edge
        if (s_nxt.base && !s_r.base) begin
            s_nxt.bus = ~s_r.bus;
        end

        // 255 * 8 * 38400 stays below 2^27
        s_nxt.center = 32'(s_r.range) * 32'(F_NOM_HZ) << s_r.e_exp;
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            s_r <= '0;
            s_r.auto_bw <= AUTO_RST;
            s_r.halve <= HALVE_RST;
            s_r.mult <= MULT_RST;
            s_r.range <= RANGE_RST;
            s_r.rdiv <= RDIV_RST;
            s_r.act_src <= SRC_OSC_HALF;
        end else if (CE) begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign REG_RDATA = s_r.rdata;
    assign BASE_CLOCK_OUT = s_r.base;
    assign BUS_CLOCK = s_r.bus;
    assign DIVIDED_REFERENCE = s_r.ref_pulse;
    assign FEEDBACK_CLOCK = s_r.fb_pulse;
    assign PUMP_UP = s_r.pd_up;
    assign PUMP_DN = s_r.pd_dn;
    // tracking only when chosen by software or by the detector
    assign FILTER_TRACK = s_r.auto_bw ? (s_r.good_cnt >= TRACK_C) : s_r.mode_sw;
    assign VCO_ENABLE = s_r.pwr;
    assign VCO_RANGE = s_r.range;
    assign VCO_EXP = s_r.e_exp;
    assign VCO_CENTER_HZ = s_r.center;
    assign CLOCK_IRQ = s_r.flag & s_r.irq_en & s_r.auto_bw;

endmodule

// file: shared/clock_gen_pkg.sv
// Purpose: constants and types for the clock generator
// Assumes: 8-bit register port, one system clock
// Notes: register offsets are byte indices on the plain register port
package clock_gen_pkg;

    // register offsets
    localparam logic [2:0] OFS_CTRL = 3'h0;
    localparam logic [2:0] OFS_BW = 3'h1;
    localparam logic [2:0] OFS_MULT_HI = 3'h2;
    localparam logic [2:0] OFS_MULT_LO = 3'h3;
    localparam logic [2:0] OFS_RANGE = 3'h4;
    localparam logic [2:0] OFS_REFDIV = 3'h5;

    // control register field positions
    localparam int CTRL_IRQ_EN = 7;
    localparam int CTRL_FLAG = 6;
    localparam int CTRL_PWR = 5;
    localparam int CTRL_BSEL = 4;
    localparam int CTRL_E_LSB = 2;
    localparam int CTRL_P_LSB = 0;

    // bandwidth register field positions
    localparam int BW_AUTO = 7;
    localparam int BW_LOCK = 6;
    localparam int BW_MODE = 5;
    localparam int BW_HALVE = 0;

    // field widths
    localparam int MULT_W = 12;
    localparam int RDIV_W = 4;
    localparam int CNT_W = 4;

    // values after reset
    localparam logic [MULT_W-1:0] MULT_RST = 12'h001;
    localparam logic [7:0] RANGE_RST = 8'h00;
    localparam logic [RDIV_W-1:0] RDIV_RST = 4'h1;
    localparam logic AUTO_RST = 1'b1;
    localparam logic HALVE_RST = 1'b1;

    // lock detector: good reference periods before tracking and before lock
    localparam int TRACK_PERIODS = 4;
    localparam int LOCK_PERIODS = 8;

    // nominal vco center-of-range step in Hz
    localparam int F_NOM_HZ = 38400;

    typedef enum logic [1:0] {SRC_OSC, SRC_OSC_HALF, SRC_PLL} src_type;

    typedef struct packed {
        logic [2:0] osc_s;
        logic [2:0] vco_s;
        logic osc_st;
        logic vco_st;
        logic irq_en;
        logic flag;
        logic pwr;
        logic bsel;
        logic [1:0] e_exp;
        logic [1:0] p_exp;
        logic auto_bw;
        logic mode_sw;
        logic halve;
        logic [MULT_W-1:0] mult;
        logic [7:0] range;
        logic [RDIV_W-1:0] rdiv;
        logic [RDIV_W-1:0] ref_cnt;
        logic ref_pulse;
        logic [2:0] pre_cnt;
        logic [MULT_W-1:0] fb_cnt;
        logic fb_pulse;
        logic [1:0] fb_seen;
        logic [CNT_W-1:0] good_cnt;
        logic lock;
        logic pd_up;
        logic pd_dn;
        src_type act_src;
        logic base;
        logic half_t;
        logic pll_t;
        logic bus;
        logic [7:0] rdata;
        logic [31:0] center;
    } state_type;

endpackage

// file: bench/clock_gen_properties.sv
// Purpose: port-level checks of the clock generator
// Assumes: bench pins far slower than CLK, CE held high
// Notes: bound from the bench top file
module clock_gen_properties
    import clock_gen_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // register port
    input wire logic [2:0] REG_ADDR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_RDATA,
    // generated clocks
    input wire logic BASE_CLOCK_OUT,
    input wire logic BUS_CLOCK,
    input wire logic DIVIDED_REFERENCE,
    // loop controls
    input wire logic PUMP_UP,
    input wire logic PUMP_DN,
    input wire logic VCO_ENABLE,
    input wire logic [7:0] VCO_RANGE,
    input wire logic [1:0] VCO_EXP,
    input wire logic [31:0] VCO_CENTER_HZ
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    ////////////////////////////////////////////////////////////
    chk_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
        else $error("read data outside its cycle");
    chk_unmapped_zero: assert property ($past(REG_RD) && $past(REG_ADDR) > 3'h5 |->
        REG_RDATA == 8'h00) else $error("unmapped read not zero");
    chk_bus_on_base: assert property ($rose(BUS_CLOCK) |-> BASE_CLOCK_OUT)
        else $error("bus clock rose without base clock");
    chk_base_high_min: assert property ($rose(BASE_CLOCK_OUT) |=> BASE_CLOCK_OUT [*3])
        else $error("runt high pulse on base clock");
    chk_base_low_min: assert property ($fell(BASE_CLOCK_OUT) |=> !BASE_CLOCK_OUT [*3])
        else $error("runt low pulse on base clock");
    chk_ref_pulse_gap: assert property (DIVIDED_REFERENCE |=> !DIVIDED_REFERENCE [*4])
        else $error("reference pulses too close");
    chk_ref_needs_power: assert property (DIVIDED_REFERENCE |-> VCO_ENABLE || $past(VCO_ENABLE))
        else $error("reference pulse while loop off");
    chk_pump_exclusive: assert property (!(PUMP_UP && PUMP_DN))
        else $error("both pump outputs high");
    chk_pump_off_idle: assert property (!VCO_ENABLE && !$past(VCO_ENABLE) |-> !PUMP_UP && !PUMP_DN)
        else $error("pump active while loop off");
    chk_center_value: assert property (VCO_CENTER_HZ ==
        ((32'(F_NOM_HZ) * {24'h0, $past(VCO_RANGE)}) << $past(VCO_EXP)))
        else $error("center frequency mismatch");
endmodule

// file: bench/system_integration_model.sv
// Purpose: consumer of the base clock, counts base and bus edges
// Assumes: base and bus are levels sampled on clk
// Notes: counts restart while clear is high
module system_integration_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // clocks from the generator and the count clear
    input wire logic base,
    input wire logic bus,
    input wire logic clear,
    // rising edges since clear
    output int base_rises,
    output int bus_rises
);
    timeunit 1ns;
    timeprecision 1ps;
    logic base_d;
    logic bus_d;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            base_d <= 1'b0;
            bus_d <= 1'b0;
            base_rises <= 0;
            bus_rises <= 0;
        end else begin
            base_d <= base;
            bus_d <= bus;
            base_rises <= clear ? 0 : base_rises + int'(base && !base_d);
            bus_rises <= clear ? 0 : bus_rises + int'(bus && !bus_d);
        end
    end
endmodule

// file: bench/clock_gen_bench.sv
// Purpose: self-checking bench of the clock generator
// Assumes: osc pin period 16 CLK, vco pin period 4 CLK
// Notes: short lock counts keep the run brief
module clock_gen_bench
    import clock_gen_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK = 1'b0;
    logic RST_N = 1'b0;
    logic ce = 1'b1;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic osc = 1'b0;
    logic vco = 1'b0;
    logic clear = 1'b0;
    logic [7:0] rdo, got, lval, vrange;
    logic [1:0] eval, vexp;
    logic base, bus, dref, fb, pup, pdn, ftrack, ven, irq;
    logic [31:0] center;
    logic [31:0] seed = 32'h55809749;
    logic [7:0] rst_val [8] = '{8'h00, 8'h81, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h00};
    int n_errors = 0;
    int checks = 0;
    int n_ref = 0;
    int n_fb = 0;
    int tick = 0;
    int nb, nu;
    always #20 CLK = ~CLK;
    // pins far below CLK, so the bus clock stays well under its ceiling
    always @(posedge CLK) begin
        tick <= tick + 1;
        vco <= (tick % 2 == 1) ? ~vco : vco;
        osc <= (tick % 8 == 7) ? ~osc : osc;
        n_ref <= clear ? 0 : n_ref + int'(dref);
        n_fb <= clear ? 0 : n_fb + int'(fb);
    end
    clock_gen #(.TRACK_N(2), .LOCK_N(3)) u_dut (
        .CLK(CLK), .RST_N(RST_N), .CE(ce), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdo), .OSC_CLK(osc), .VCO_CLK(vco),
        .BASE_CLOCK_OUT(base), .BUS_CLOCK(bus), .DIVIDED_REFERENCE(dref),
        .FEEDBACK_CLOCK(fb), .PUMP_UP(pup), .PUMP_DN(pdn), .FILTER_TRACK(ftrack),
        .VCO_ENABLE(ven), .VCO_RANGE(vrange), .VCO_EXP(vexp),
        .VCO_CENTER_HZ(center), .CLOCK_IRQ(irq));
    system_integration_model u_sys (.clk(CLK), .rst_n(RST_N), .base(base), .bus(bus),
        .clear(clear), .base_rises(nb), .bus_rises(nu));
    ////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // edge counts in a window may be off by one
    function automatic int near(input int n, input int e);
        return (n >= e - 1 && n <= e + 1) ? e : n;
    endfunction
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wreg(input logic [2:0] a, input logic [7:0] d);
        @(posedge CLK);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge CLK);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [2:0] a);
        @(posedge CLK);
        addr <= a;
        rd <= 1'b1;
        @(posedge CLK);
        rd <= 1'b0;
        @(negedge CLK);
        got = rdo;
    endtask
    task automatic expect_reg(input string what, input logic [2:0] a, input logic [7:0] e);
        rreg(a);
        chk(what, {24'h0, got}, {24'h0, e});
    endtask
    task automatic window(input int eb, input int eref, input int efb);
        @(posedge CLK);
        clear <= 1'b1;
        @(posedge CLK);
        clear <= 1'b0;
        repeat (320) @(posedge CLK);
        @(negedge CLK);
        chk("base rises", 32'(near(nb, eb)), 32'(eb));
        chk("bus rises", 32'(near(nu, eb / 2)), 32'(eb / 2));
        chk("ref pulses", 32'(near(n_ref, eref)), 32'(eref));
        chk("fb pulses", 32'(near(n_fb, efb)), 32'(efb));
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge CLK);
        RST_N <= 1'b1;
        repeat (4) @(posedge CLK);
        seed = xs(seed);
        wreg(3'h6 + {2'h0, seed[0]}, seed[15:8]);
        for (int i = 0; i < 8; i++) begin
            expect_reg("reset value", 3'(i), rst_val[i]);
        end
        wreg(OFS_CTRL, 8'h30);
        expect_reg("select with zero range", OFS_CTRL, 8'h20);
        wreg(OFS_CTRL, 8'h00);
        seed = xs(seed);
        lval = seed[7:0] | 8'h01;
        eval = (seed[9:8] == 2'h3) ? 2'h2 : seed[9:8];
        wreg(OFS_MULT_LO, 8'h02);
        wreg(OFS_RANGE, lval);
        wreg(OFS_REFDIV, 8'h02);
        wreg(OFS_CTRL, {4'h2, eval, 2'h1});
        repeat (2) @(negedge CLK);
        chk("center", center, (32'(F_NOM_HZ) * {24'h0, lval}) << eval);
        chk("range pins", {22'h0, vexp, vrange}, {22'h0, eval, lval});
        chk("vco enable on", {31'h0, ven}, 32'h1);
        wreg(OFS_MULT_LO, 8'h55);
        expect_reg("locked multiplier", OFS_MULT_LO, 8'h02);
        window(10, 10, 20);
        wreg(OFS_CTRL, 8'h00);
        wreg(OFS_REFDIV, 8'h01);
        @(negedge CLK);
        chk("pumps idle", {30'h0, pup, pdn}, 32'h0);
        chk("vco enable off", {31'h0, ven}, 32'h0);
        wreg(OFS_CTRL, {4'hA, eval, 2'h1});
        got = 8'h00;
        for (int i = 0; i < 100 && !got[BW_LOCK]; i++) begin
            rreg(OFS_BW);
        end
        chk("irq on lock", {31'h0, irq}, 32'h1);
        expect_reg("tracking", OFS_BW, 8'hE1);
        chk("filter track pin", {31'h0, ftrack}, 32'h1);
        wreg(OFS_BW, 8'h81);
        expect_reg("mode write ignored", OFS_BW, 8'hE1);
        expect_reg("flag set", OFS_CTRL, {4'hE, eval, 2'h1});
        expect_reg("flag cleared", OFS_CTRL, {4'hA, eval, 2'h1});
        chk("irq cleared", {31'h0, irq}, 32'h0);
        window(10, 20, 20);
        wreg(OFS_CTRL, {4'hB, eval, 2'h1});
        window(20, 20, 20);
        wreg(OFS_CTRL, {4'h9, eval, 2'h1});
        expect_reg("power held", OFS_CTRL, {4'hB, eval, 2'h1});
        wreg(OFS_CTRL, {4'hA, eval, 2'h1});
        wreg(OFS_BW, 8'h80);
        window(20, 20, 20);
        wreg(OFS_BW, 8'h00);
        expect_reg("manual control", OFS_CTRL, {4'h2, eval, 2'h1});
        expect_reg("manual bandwidth", OFS_BW, 8'h00);
        wreg(OFS_BW, 8'h20);
        expect_reg("manual mode", OFS_BW, 8'h20);
        wreg(OFS_CTRL, {4'hA, eval, 2'h1});
        expect_reg("enable held clear", OFS_CTRL, {4'h2, eval, 2'h1});
        tally_and_finish;
    end
    initial begin
        repeat (20000) @(posedge CLK);
        n_errors++;
        tally_and_finish;
    end
endmodule

bind clock_gen clock_gen_properties u_props (.CLK(CLK), .RST_N(RST_N),
    .REG_ADDR(REG_ADDR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .BASE_CLOCK_OUT(BASE_CLOCK_OUT), .BUS_CLOCK(BUS_CLOCK),
    .DIVIDED_REFERENCE(DIVIDED_REFERENCE), .PUMP_UP(PUMP_UP), .PUMP_DN(PUMP_DN),
    .VCO_ENABLE(VCO_ENABLE), .VCO_RANGE(VCO_RANGE), .VCO_EXP(VCO_EXP),
    .VCO_CENTER_HZ(VCO_CENTER_HZ));
